// File: hw/dstp_timer.sv
// Dual-slope 16-bit timer with two PWM compare channels
`timescale 1ns/10ps
module dstp_timer
  import dstp_pkg::*;
#(
  parameter int W = CNT_W
)
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic [2:0]   prescale_sel,
  input  wire logic [3:0]   waveform_mode,
  input  wire logic [1:0]   output_mode_field_a,
  input  wire logic [1:0]   output_mode_field_b,
  input  wire logic         pin_direction_a,
  input  wire logic         pin_direction_b,
  input  wire logic         port_data_a,
  input  wire logic         port_data_b,
  input  wire logic         compare_a_wr,
  input  wire logic         compare_b_wr,
  input  wire logic [W-1:0] compare_wdata,
  input  wire logic         capture_top_wr,
  input  wire logic [W-1:0] capture_top_wdata,
  input  wire logic         overflow_clr,
  input  wire logic         compare_a_clr,
  input  wire logic         compare_b_clr,
  input  wire logic         capture_clr,
  output logic [W-1:0]      counter_value,
  output logic              overflow_flag,
  output logic              compare_a_flag,
  output logic              compare_b_flag,
  output logic              capture_flag,
  output logic              counting_down,
  output logic              pin_out_a,
  output logic              pin_oe_n_a,
  output logic              pin_out_b,
  output logic              pin_oe_n_b
);
  if (W != 16)
  begin : g_width_check
    $error("dstp_timer supports only a 16-bit counter");
  end

  logic         timer_tick;
  logic [W-1:0] capture_top;
  logic [W-1:0] compare_a;
  logic [W-1:0] compare_b;
  logic         match_a;
  logic         match_b;
  logic         wave_out_a;
  logic         wave_out_b;
  logic         next_pin_a;
  logic         next_pin_b;

  // Mode decode
  wire logic       mode_pc    = (waveform_mode == WM_PC8) || (waveform_mode == WM_PC9) ||
                                (waveform_mode == WM_PC10) || (waveform_mode == WM_PC_CAP) ||
                                (waveform_mode == WM_PC_CMPA);
  wire logic       mode_pfc   = (waveform_mode == WM_PFC_CAP) ||
                                (waveform_mode == WM_PFC_CMPA);
  wire logic       dual_slope = mode_pc || mode_pfc;
  wire logic       top_is_a   = (waveform_mode == WM_PC_CMPA) ||
                                (waveform_mode == WM_PFC_CMPA);
  wire logic       top_is_cap = (waveform_mode == WM_PC_CAP) ||
                                (waveform_mode == WM_PFC_CAP);
  wire logic [W-1:0] fixed_top = (waveform_mode == WM_PC8)  ? TOP_8BIT :
                                 (waveform_mode == WM_PC9)  ? TOP_9BIT :
                                 (waveform_mode == WM_PC10) ? TOP_10BIT : '1;
  // Variable TOP: capture_top acts at once, compare_a through its buffer
  wire logic [W-1:0] top_raw  = top_is_a   ? compare_a :
                                top_is_cap ? capture_top : fixed_top;
  // TOP below the minimum is clamped so the counter can still turn round
  wire logic [W-1:0] top_val  = (top_raw < TOP_MIN) ? TOP_MIN : top_raw;
  wire logic [W-1:0] wr_mask  = (top_is_a || top_is_cap) ? '1 : fixed_top;

  wire logic at_top    = (counter_value == top_val);
  wire logic at_bottom = (counter_value == BOTTOM_VAL);
  // TOP is seen only once per period, so a match there acts as the down slope
  wire logic slope_down = counting_down || at_top;
  // Direction turns on reaching either end; above TOP it wraps through MAX
  wire logic turn_down = !counting_down && at_top;
  wire logic turn_up   = counting_down && (counter_value == BOTTOM_VAL + 16'h0001);
  wire logic [W-1:0] next_count = counting_down ? counter_value - 16'h0001
                                                : counter_value + 16'h0001;
  wire logic load_now  = (mode_pc && at_top) || (mode_pfc && at_bottom);

  wire logic set_ovf   = timer_tick && dual_slope && at_bottom;
  wire logic set_top_a = timer_tick && top_is_a && dual_slope && at_top;
  wire logic set_cap   = timer_tick && top_is_cap && dual_slope && at_top;
  wire logic set_cmp_a = set_top_a || (timer_tick && match_a);
  wire logic set_cmp_b = timer_tick && match_b;

  // Connect wave only in dual-slope modes with a live output mode
  wire logic drive_a   = dual_slope && (output_mode_field_a != OM_OFF) &&
                         !((output_mode_field_a == OM_TOGGLE) && !top_is_a);
  wire logic drive_b   = dual_slope && (output_mode_field_b[1] == 1'b1);

  assign next_pin_a = drive_a ? wave_out_a : port_data_a;
  assign next_pin_b = drive_b ? wave_out_b : port_data_b;

  dstp_prescaler u_pre
  (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .prescale_sel (prescale_sel),
    .timer_tick   (timer_tick)
  );

  dstp_channel #(.W(W)) u_ch_a
  (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .tick              (timer_tick && dual_slope),
    .load_now          (load_now),
    .wr_en             (compare_a_wr),
    .wr_data           (compare_wdata),
    .fixed_mask        (wr_mask),
    .counter_value     (counter_value),
    .counting_down     (slope_down),
    .output_mode_field (output_mode_field_a),
    .toggle_ok         (top_is_a),
    .compare_value     (compare_a),
    .match_now         (match_a),
    .wave_out          (wave_out_a)
  );

  dstp_channel #(.W(W)) u_ch_b
  (
    .core_clk          (core_clk),
    .arst_n            (arst_n),
    .clk_en            (clk_en),
    .tick              (timer_tick && dual_slope),
    .load_now          (load_now),
    .wr_en             (compare_b_wr),
    .wr_data           (compare_wdata),
    .fixed_mask        (wr_mask),
    .counter_value     (counter_value),
    .counting_down     (slope_down),
    .output_mode_field (output_mode_field_b),
    .toggle_ok         (1'b0),
    .compare_value     (compare_b),
    .match_now         (match_b),
    .wave_out          (wave_out_b)
  );

  // Counter and direction, advanced only on the tick
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      counter_value <= BOTTOM_VAL;
      counting_down <= 1'b0;
    end
    else if (clk_en && timer_tick && dual_slope)
    begin
      counter_value <= turn_down ? counter_value - 16'h0001 : next_count;
      if (turn_down)
        counting_down <= 1'b1;
      else if (turn_up || (counting_down && at_bottom))
        counting_down <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      capture_top <= '0;
    else if (clk_en && capture_top_wr)
      capture_top <= capture_top_wdata;
  end

  // Flags: a set in the same cycle as a clear wins
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      overflow_flag  <= 1'b0;
      compare_a_flag <= 1'b0;
      compare_b_flag <= 1'b0;
      capture_flag   <= 1'b0;
    end
    else if (clk_en)
    begin
      overflow_flag  <= set_ovf   || (overflow_flag  && !overflow_clr);
      compare_a_flag <= set_cmp_a || (compare_a_flag && !compare_a_clr);
      compare_b_flag <= set_cmp_b || (compare_b_flag && !compare_b_clr);
      capture_flag   <= set_cap   || (capture_flag   && !capture_clr);
    end
  end

  // Pin drive registered; enable is low while driving
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out_a  <= 1'b0;
      pin_oe_n_a <= 1'b1;
      pin_out_b  <= 1'b0;
      pin_oe_n_b <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_out_a  <= next_pin_a;
      pin_oe_n_a <= !pin_direction_a;
      pin_out_b  <= next_pin_b;
      pin_oe_n_b <= !pin_direction_b;
    end
  end
endmodule

// File: hw/dstp_pkg.sv
// Constants and types for the dual-slope timer PWM block
package dstp_pkg;
  localparam int          CNT_W        = 16;
  localparam logic [15:0] BOTTOM_VAL   = 16'h0000;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;
  localparam logic [15:0] TOP_MIN      = 16'h0003;
  localparam logic [3:0]  WM_PC8       = 4'h1;
  localparam logic [3:0]  WM_PC9       = 4'h2;
  localparam logic [3:0]  WM_PC10      = 4'h3;
  localparam logic [3:0]  WM_PFC_CAP   = 4'h8;
  localparam logic [3:0]  WM_PFC_CMPA  = 4'h9;
  localparam logic [3:0]  WM_PC_CAP    = 4'ha;
  localparam logic [3:0]  WM_PC_CMPA   = 4'hb;
  localparam logic [1:0]  OM_OFF       = 2'h0;
  localparam logic [1:0]  OM_TOGGLE    = 2'h1;
  localparam logic [1:0]  OM_NONINV    = 2'h2;
  localparam logic [1:0]  OM_INV       = 2'h3;
  localparam logic [2:0]  PRE_STOP     = 3'h0;
  localparam logic [2:0]  PRE_DIV1     = 3'h1;
  localparam logic [2:0]  PRE_DIV8     = 3'h2;
  localparam logic [2:0]  PRE_DIV64    = 3'h3;
  localparam logic [2:0]  PRE_DIV256   = 3'h4;
  localparam logic [2:0]  PRE_DIV1024  = 3'h5;
  localparam logic [9:0]  DIV8_LAST    = 10'h007;
  localparam logic [9:0]  DIV64_LAST   = 10'h03f;
  localparam logic [9:0]  DIV256_LAST  = 10'h0ff;
  localparam logic [9:0]  DIV1024_LAST = 10'h3ff;
  localparam logic        WAVE_RESET   = 1'b0;

  typedef enum logic [1:0] {
    DSTP_UP   = 2'b00,
    DSTP_DOWN = 2'b01
  } dstp_dir_e;
endpackage

// File: hw/dstp_prescaler.sv
// Prescaler producing the one-cycle timer tick enable
`timescale 1ns/10ps
module dstp_prescaler
  import dstp_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic [2:0] prescale_sel,
  output logic            timer_tick
);
  logic [9:0] div_cnt;
  logic [9:0] last_val;
  logic       tick_hit;

  assign last_val = (prescale_sel == PRE_DIV8)    ? DIV8_LAST :
                    (prescale_sel == PRE_DIV64)   ? DIV64_LAST :
                    (prescale_sel == PRE_DIV256)  ? DIV256_LAST :
                    (prescale_sel == PRE_DIV1024) ? DIV1024_LAST : 10'h000;
  assign tick_hit = (prescale_sel == PRE_DIV1) ||
                    ((prescale_sel != PRE_STOP) && (div_cnt >= last_val));

  // Tick is a clock enable, never a derived clock
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt    <= 10'h000;
      timer_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      div_cnt    <= tick_hit ? 10'h000 : div_cnt + 10'h001;
      timer_tick <= tick_hit;
    end
  end
endmodule

// File: hw/dstp_channel.sv
// One compare channel: buffer, active compare, match and waveform
`timescale 1ns/10ps
module dstp_channel
  import dstp_pkg::*;
#(
  parameter int W = CNT_W
)
(
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic         tick,
  input  wire logic         load_now,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] fixed_mask,
  input  wire logic [W-1:0] counter_value,
  input  wire logic         counting_down,
  input  wire logic [1:0]   output_mode_field,
  input  wire logic         toggle_ok,
  output logic [W-1:0]      compare_value,
  output logic              match_now,
  output logic              wave_out
);
  logic [W-1:0] buffer_value;
  logic         next_wave;

  assign match_now = (counter_value == compare_value);
  always_comb
  begin
    next_wave = wave_out;
    if (match_now)
    begin
      unique case (output_mode_field)
        OM_TOGGLE: next_wave = toggle_ok ? !wave_out : wave_out;
        OM_NONINV: next_wave = counting_down;
        OM_INV:    next_wave = !counting_down;
        OM_OFF:    next_wave = wave_out;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buffer_value  <= '0;
      compare_value <= '0;
      wave_out      <= WAVE_RESET;
    end
    else if (clk_en)
    begin
      if (wr_en)
        buffer_value <= wr_data & fixed_mask;
      if (tick && load_now)
        compare_value <= buffer_value;
      if (tick)
        wave_out <= next_wave;
    end
  end
endmodule

// File: test/dstp_timer_chk.sv
// Port-level assertions for the dual-slope timer PWM block
`timescale 1ns/10ps
module dstp_timer_chk
  import dstp_pkg::*;
#(
  parameter int W = CNT_W
)
(
  input wire logic         core_clk,
  input wire logic         arst_n,
  input wire logic         clk_en,
  input wire logic [3:0]   waveform_mode,
  input wire logic [1:0]   output_mode_field_a,
  input wire logic         pin_direction_a,
  input wire logic         pin_direction_b,
  input wire logic         port_data_a,
  input wire logic         capture_top_wr,
  input wire logic [W-1:0] capture_top_wdata,
  input wire logic         overflow_clr,
  input wire logic         compare_b_clr,
  input wire logic [W-1:0] counter_value,
  input wire logic         overflow_flag,
  input wire logic         compare_b_flag,
  input wire logic         capture_flag,
  input wire logic         pin_out_a,
  input wire logic         pin_oe_n_a,
  input wire logic         pin_oe_n_b
);
  logic [W-1:0] cap_q;
  // Shadow of the unbuffered TOP source, taken on the same edge as the design
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      cap_q <= '0;
    else if (clk_en && capture_top_wr)
      cap_q <= capture_top_wdata;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_step_unit:
    assert property (counter_value != $past(counter_value) |-> counter_value ==
      $past(counter_value) + 1'b1 || counter_value == $past(counter_value) - 1'b1)
      else $error("counter jumped");
  chk_ovf_at_bottom:
    assert property ($past(counter_value) == BOTTOM_VAL && counter_value == 1 |-> overflow_flag)
      else $error("overflow not set leaving bottom");
  chk_ovf_only_bottom:
    assert property ($rose(overflow_flag) |-> $past(counter_value) == BOTTOM_VAL)
      else $error("overflow set away from bottom");
  chk_cap_flag_top:
    assert property ($rose(capture_flag) |-> $past(counter_value) == $past(cap_q))
      else $error("capture flag set away from top");
  chk_cap_turn:
    assert property ((waveform_mode == WM_PFC_CAP || waveform_mode == WM_PC_CAP) &&
      cap_q >= TOP_MIN && counter_value == cap_q ##1 counter_value != $past(counter_value)
      |-> capture_flag && counter_value == cap_q - 1'b1)
      else $error("no turn at capture top");
  chk_oe_follows_dir:
    assert property ($past(arst_n) |-> pin_oe_n_a == !$past(pin_direction_a) &&
      pin_oe_n_b == !$past(pin_direction_b))
      else $error("pin enable wrong");
  chk_port_normal:
    assert property ($past(arst_n) && $past(output_mode_field_a) == OM_OFF |->
      pin_out_a == $past(port_data_a))
      else $error("port data not on pin");
  chk_ovf_sticky:
    assert property (overflow_flag && !overflow_clr |=> overflow_flag)
      else $error("overflow lost");
  chk_cmpb_clear:
    assert property ($fell(compare_b_flag) |-> $past(compare_b_clr))
      else $error("compare flag lost");
endmodule

bind dstp_timer dstp_timer_chk #(.W(W)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .waveform_mode(waveform_mode),
  .output_mode_field_a(output_mode_field_a), .pin_direction_a(pin_direction_a),
  .pin_direction_b(pin_direction_b), .port_data_a(port_data_a),
  .capture_top_wr(capture_top_wr), .capture_top_wdata(capture_top_wdata),
  .overflow_clr(overflow_clr), .compare_b_clr(compare_b_clr), .counter_value(counter_value),
  .overflow_flag(overflow_flag), .compare_b_flag(compare_b_flag), .capture_flag(capture_flag),
  .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a), .pin_oe_n_b(pin_oe_n_b)
);

// File: test/dual_slope_timer_pwm_tb.sv
// Self-checking random bench for the dual-slope timer PWM block
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module dual_slope_timer_pwm_tb
  import dstp_pkg::*;
;
  localparam logic [3:0] MODES [7] = '{WM_PC_CAP, WM_PFC_CMPA, WM_PFC_CAP, WM_PC8,
                                       WM_PC_CMPA, WM_PC9, WM_PC10};
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic [2:0]  presc    = PRE_DIV1;
  logic [3:0]  wmode    = WM_PC8;
  logic [1:0]  om_a     = OM_OFF;
  logic [1:0]  om_b     = OM_OFF;
  logic        dir_a    = 1'b0;
  logic        dir_b    = 1'b0;
  logic        pd_a     = 1'b0;
  logic        wr_a     = 1'b0;
  logic        wr_b     = 1'b0;
  logic        wr_cap   = 1'b0;
  logic        clr      = 1'b0;
  logic [15:0] wdata    = 16'h0000;
  logic [15:0] cdata    = 16'h0000;
  logic [15:0] cnt;
  logic        ovf, fa, fb, fc, down, pa, oa, pb, ob;
  int          err_count   = 0;
  int          check_count = 0;

  always #12.5 core_clk = ~core_clk;

  dstp_timer dut (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .prescale_sel(presc),
    .waveform_mode(wmode), .output_mode_field_a(om_a), .output_mode_field_b(om_b),
    .pin_direction_a(dir_a), .pin_direction_b(dir_b), .port_data_a(pd_a), .port_data_b(1'b0),
    .compare_a_wr(wr_a), .compare_b_wr(wr_b), .compare_wdata(wdata),
    .capture_top_wr(wr_cap), .capture_top_wdata(cdata), .overflow_clr(clr),
    .compare_a_clr(clr), .compare_b_clr(clr), .capture_clr(clr), .counter_value(cnt),
    .overflow_flag(ovf), .compare_a_flag(fa), .compare_b_flag(fb), .capture_flag(fc),
    .counting_down(down), .pin_out_a(pa), .pin_oe_n_a(oa), .pin_out_b(pb), .pin_oe_n_b(ob)
  );

  // High cycles of channel B over two whole PWM periods
  function automatic int exp_hi(logic [1:0] om, int c, int t, int n);
    if (c > t)
      return 0;
    return (om == OM_NONINV) ? 4 * n * c : 4 * n * (t - c);
  endfunction

  task automatic leave_bottom();
    int k;
    k = 0;
    while (cnt !== 16'h0000 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    while (cnt === 16'h0000 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    `CHK("bottom reached", 1'b1, k < 5000)
  endtask

  task automatic run_case(int i);
    logic [3:0]  m;
    logic [15:0] top, c;
    logic        fixed, cmpa_top, cap_top;
    int          k, n, ha, hb, hd;
    m = MODES[i];
    fixed = m < 4'h4;
    cmpa_top = m == WM_PFC_CMPA || m == WM_PC_CMPA;
    cap_top = m == WM_PFC_CAP || m == WM_PC_CAP;
    top = (m == WM_PC8) ? TOP_8BIT : (m == WM_PC9) ? TOP_9BIT : (m == WM_PC10) ? TOP_10BIT
        : 16'(3 + $urandom % 10);
    k = fixed ? 0 : $urandom % 3;
    n = 1 << (3 * k);
    c = (i == 0) ? 16'h0000 : (i == 1) ? top : (i == 2) ? top + 16'h0001
      : 16'($urandom % (int'(top) + 1));
    @(posedge core_clk);
    arst_n <= 1'b0;
    wmode <= m;
    presc <= 3'(PRE_DIV1 + k);
    om_a <= cmpa_top ? OM_TOGGLE : 2'($urandom % 2);
    om_b <= (i == 2) ? OM_NONINV : 2'(2 + $urandom % 2);
    dir_a <= 1'($urandom);
    dir_b <= 1'($urandom);
    pd_a <= 1'($urandom);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("reset state", {16'h0000, 5'b00001}, {cnt, ovf, fb, down, pb, ob})
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    wr_a <= cmpa_top;
    wr_cap <= cap_top;
    wdata <= top;
    cdata <= top;
    @(posedge core_clk);
    wr_a <= 1'b0;
    wr_cap <= 1'b0;
    wr_b <= 1'b1;
    // Junk above the fixed resolution must be dropped by the design
    wdata <= c | (fixed ? ~top & 16'($urandom) : 16'h0000);
    @(posedge core_clk);
    wr_b <= 1'b0;
    repeat (3) leave_bottom();
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    ha = 0;
    hb = 0;
    hd = 0;
    repeat (4 * int'(top) * n)
    begin
      @(negedge core_clk);
      ha += int'(pa === 1'b1);
      hb += int'(pb === 1'b1);
      hd += int'(down === 1'b1);
    end
    `CHK("wave b high", exp_hi(om_b, int'(c), int'(top), n), hb)
    `CHK("wave a high", cmpa_top ? 2 * int'(top) * n : (pd_a ? 4 * int'(top) * n : 0), ha)
    `CHK("down slope", 2 * (int'(top) - 1) * n, hd)
    `CHK("flags", {1'b1, 1'b1, c <= top, cap_top, !dir_a, !dir_b}, {ovf, fa, fb, fc, oa, ob})
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h1789));
    for (int i = 0; i < 7; i++)
      run_case(i);
    report_and_stop();
  end

  // Worst case is about 50000 cycles for all cases
  initial
  begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
endmodule
